// ---- pkg/wkhs_defines.svh ----
`ifndef WKHS_DEFINES_SVH
`define WKHS_DEFINES_SVH

// Register addresses (7-bit SPI address space)
`define WKHS_ADDR_WAKE_SRC 7'h44
`define WKHS_ADDR_WAKE_LVL 7'h45
`define WKHS_ADDR_HS_FAULT 7'h46

// Wake source field positions
`define WKHS_WS_PIN_LSB 0
`define WKHS_WS_TMR_A_BIT 7
`define WKHS_WS_TMR_B_BIT 8
`define WKHS_WS_CAN_BIT 9
`define WKHS_WS_LIN_BIT 10

// Wake level field position
`define WKHS_WL_PIN_LSB 0

// High-side fault field positions
`define WKHS_HS_OC_LSB 0
`define WKHS_HS_OL_LSB 5
`define WKHS_HS_OT_LSB 10

// Reset values
`define WKHS_RST_WAKE_SRC 16'h0000
`define WKHS_RST_HS_FAULT 16'h0000

`endif

// ---- pkg/wkhs_pkg.sv ----
package wkhs_pkg;

  // Wake detector events, one-cycle pulses
  typedef struct packed {
    logic [3:0] pin;
    logic tmr_a;
    logic tmr_b;
    logic can;
    logic lin;
  } wkhs_wake_ev_t;

  // High-side detector events, one bit per switch
  typedef struct packed {
    logic [3:0] ot;
    logic [3:0] ol;
    logic [3:0] oc;
  } wkhs_hs_ev_t;

  // Register read port from the SPI engine
  typedef struct packed {
    logic rd_req;
    logic [6:0] addr;
  } wkhs_rd_t;

  // Chip operating state as seen by this block
  typedef enum logic [2:0] {
    WKHS_MODE_NORMAL,
    WKHS_MODE_STOP,
    WKHS_MODE_INIT,
    WKHS_MODE_RESTART,
    WKHS_MODE_SLEEP,
    WKHS_MODE_FAILSAFE
  } wkhs_mode_t;

endpackage

// ---- design/wkhs_sticky.sv ----
`timescale 1ns/1ns
`include "wkhs_defines.svh"

module wkhs_sticky #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Events and clears
  input wire logic [WIDTH-1:0] set_in,
  input wire logic clr_in,
  // Flags
  output logic [WIDTH-1:0] flags_out
);

  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;

  // Set beats clear so an event during a read survives
  always_comb begin
    nxt_flags = flags_ff;
    if (clr_in) begin
      nxt_flags = '0;
    end
    nxt_flags = nxt_flags | set_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags_ff <= '0;
    end else if (clk_en_in) begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_out = flags_ff;

endmodule // wkhs_sticky

// ---- design/wkhs_status_regs.sv ----
`timescale 1ns/1ns
`include "wkhs_defines.svh"
// Contract
// - Wake pin flags bits 0-3, clear on read
// - Timer wake flags bits 7 and 8
// - CAN bit 9, LIN bit 10 wake flags
// - Reserved bits always read zero
// - Fail-safe entry clears wake source register
// - Level register bits 0-3 show pin levels
// - Levels tracked in Normal, Stop, Init, Restart
// - Cyclic sensing holds last sampled level
// - Overtemperature flags bits 10-13, clear on read
// - Open-load flags bits 5-8, clear on read
// - Overcurrent switch four bit 3, three bit 2
// - Overcurrent switch two bit 1, one bit 0

module wkhs_status_regs #(
  parameter int PINS = 4
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Operating state and wake pin sensing
  input wire wkhs_pkg::wkhs_mode_t mode_in,
  input wire logic [PINS-1:0] wake_pin_in,
  input wire logic cyclic_sense_in,
  input wire logic sample_strobe_in,
  // Detector events
  input wire wkhs_pkg::wkhs_wake_ev_t wake_ev_in,
  input wire wkhs_pkg::wkhs_hs_ev_t hs_ev_in,
  // Register read from SPI engine
  input wire wkhs_pkg::wkhs_rd_t rd_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out
);

  // Pin synchroniser; first stage feeds only the second
  logic [PINS-1:0] pin_meta_ff;
  logic [PINS-1:0] pin_sync_ff;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else if (clk_en_in) begin
      pin_meta_ff <= wake_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Read decode; one match function keeps the three decodes alike
  function automatic logic addr_hit(input wkhs_pkg::wkhs_rd_t rd, input logic [6:0] addr);
    return rd.rd_req && (rd.addr == addr);
  endfunction
  logic rd_src;
  logic rd_lvl;
  logic rd_hs;
  assign rd_src = addr_hit(rd_in, `WKHS_ADDR_WAKE_SRC);
  assign rd_lvl = addr_hit(rd_in, `WKHS_ADDR_WAKE_LVL);
  assign rd_hs = addr_hit(rd_in, `WKHS_ADDR_HS_FAULT);

  // Fail-safe entry detect on mode change
  wkhs_pkg::wkhs_mode_t mode_ff;
  logic fs_entry;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_ff <= wkhs_pkg::WKHS_MODE_INIT;
    end else if (clk_en_in) begin
      mode_ff <= mode_in;
    end
  end
  assign fs_entry = (mode_in == wkhs_pkg::WKHS_MODE_FAILSAFE) &&
                    (mode_ff != wkhs_pkg::WKHS_MODE_FAILSAFE);

  // Wake source flags
  logic [7:0] ws_set;
  logic [7:0] ws_flags;
  assign ws_set = {wake_ev_in.lin, wake_ev_in.can, wake_ev_in.tmr_b, wake_ev_in.tmr_a,
                   wake_ev_in.pin};

  wkhs_sticky #(.WIDTH(8)) u_ws (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .set_in(ws_set),
    .clr_in(rd_src || fs_entry),
    .flags_out(ws_flags)
  );

  // High-side fault flags
  logic [11:0] hs_flags;
  wkhs_sticky #(.WIDTH(12)) u_hs (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .set_in({hs_ev_in.ot, hs_ev_in.ol, hs_ev_in.oc}),
    .clr_in(rd_hs),
    .flags_out(hs_flags)
  );

  // Level register; without cyclic sensing, sleep freezes it since detectors are off there
  logic [PINS-1:0] lvl_ff;
  logic [PINS-1:0] nxt_lvl;
  logic lvl_live;
  assign lvl_live = (mode_in == wkhs_pkg::WKHS_MODE_NORMAL) ||
                    (mode_in == wkhs_pkg::WKHS_MODE_STOP) ||
                    (mode_in == wkhs_pkg::WKHS_MODE_INIT) ||
                    (mode_in == wkhs_pkg::WKHS_MODE_RESTART);
  always_comb begin
    nxt_lvl = lvl_ff;
    if (cyclic_sense_in) begin
      if (sample_strobe_in) begin
        nxt_lvl = pin_sync_ff;
      end
    end else if (lvl_live) begin
      nxt_lvl = pin_sync_ff;
    end
  end
  // levels reset low, then follow pins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lvl_ff <= '0;
    end else if (clk_en_in) begin
      lvl_ff <= nxt_lvl;
    end
  end

  // Read data mux, registered
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic rvalid_ff;
  always_comb begin
    nxt_rdata = 16'h0000;
    case (rd_in.addr)
      `WKHS_ADDR_WAKE_SRC: begin
        nxt_rdata[`WKHS_WS_PIN_LSB +: 4] = ws_flags[3:0];
        nxt_rdata[`WKHS_WS_TMR_A_BIT] = ws_flags[4];
        nxt_rdata[`WKHS_WS_TMR_B_BIT] = ws_flags[5];
        nxt_rdata[`WKHS_WS_CAN_BIT] = ws_flags[6];
        nxt_rdata[`WKHS_WS_LIN_BIT] = ws_flags[7];
      end
      `WKHS_ADDR_WAKE_LVL: nxt_rdata[`WKHS_WL_PIN_LSB +: PINS] = lvl_ff;
      `WKHS_ADDR_HS_FAULT: begin
        nxt_rdata[`WKHS_HS_OC_LSB +: 4] = hs_flags[3:0];
        nxt_rdata[`WKHS_HS_OL_LSB +: 4] = hs_flags[7:4];
        nxt_rdata[`WKHS_HS_OT_LSB +: 4] = hs_flags[11:8];
      end
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Capture the snapshot in the read cycle, before the clear lands
  logic nxt_rvalid;
  logic [15:0] nxt_rhold;
  always_comb begin
    nxt_rvalid = rd_in.rd_req;
    // Data holds between reads so a slow host can still fetch it
    nxt_rhold = rdata_ff;
    if (rd_in.rd_req) begin
      nxt_rhold = nxt_rdata;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else if (clk_en_in) begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rhold;
    end
  end

  assign rd_data_out = rdata_ff;
  assign rd_valid_out = rvalid_ff;

  // Assertions
  reset_flags_a: assert property (@(posedge clk_in)
    $fell(sys_rst_in) |-> (ws_flags == 8'h00 && hs_flags == 12'h000))
    else $error("flags not zero after reset");

  pin_wake_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && wake_ev_in.pin[0]) |=> ws_flags[0])
    else $error("pin wake flag not set");

  timer_wake_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && wake_ev_in.tmr_b) |=> ws_flags[5])
    else $error("timer wake flag not set");

  bus_wake_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && rd_src && ws_flags[6]) |=> rd_data_out[9])
    else $error("CAN wake bit wrong in read");

  reserved_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rd_valid_out |-> (rd_data_out[15:14] == 2'b00 && rd_data_out[4] == 1'b0))
    else $error("reserved bits nonzero");

  failsafe_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && fs_entry && ws_set == 8'h00) |=> ws_flags == 8'h00)
    else $error("fail-safe did not clear wake flags");

  level_track_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && lvl_live && !cyclic_sense_in) |=> lvl_ff == $past(pin_sync_ff))
    else $error("level not tracking pins");

  level_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && cyclic_sense_in && !sample_strobe_in) |=> $stable(lvl_ff))
    else $error("sampled level changed between samples");

  hs_read_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && rd_hs && hs_ev_in == 12'h000) |=> hs_flags == 12'h000)
    else $error("high-side flags not cleared on read");

  read_race_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && rd_hs && hs_ev_in.ot[3]) |=> hs_flags[11])
    else $error("event lost during read");

  // Reserved bits of each register, checked on the word returned
  src_resv_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $past(clk_en_in && rd_src) |-> ((rd_data_out & 16'hF870) == 16'h0000))
    else $error("wake source reserved bits nonzero");

  lvl_resv_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $past(clk_en_in && rd_lvl) |-> ((rd_data_out >> PINS) == 16'h0000))
    else $error("level reserved bits nonzero");

  hs_resv_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $past(clk_en_in && rd_hs) |-> ((rd_data_out & 16'hC210) == 16'h0000))
    else $error("high-side reserved bits nonzero");

  // Read data carries the register contents of the read cycle
  level_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && rd_lvl) |=> (rd_data_out[PINS-1:0] == $past(lvl_ff)))
    else $error("level read wrong");

  oc_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && rd_hs) |=> (rd_data_out[3:0] == $past(hs_flags[3:0])))
    else $error("overcurrent read bits wrong");

  // Each detector group sets its own flags
  timer_a_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && wake_ev_in.tmr_a) |=> ws_flags[4])
    else $error("first timer wake flag not set");

  can_wake_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && wake_ev_in.can) |=> ws_flags[6])
    else $error("CAN wake flag not set");

  lin_wake_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && wake_ev_in.lin) |=> ws_flags[7])
    else $error("LIN wake flag not set");

  overtemp_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in |=> ((hs_flags[11:8] & $past(hs_ev_in.ot)) == $past(hs_ev_in.ot)))
    else $error("overtemperature flag not set");

  open_load_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in |=> ((hs_flags[7:4] & $past(hs_ev_in.ol)) == $past(hs_ev_in.ol)))
    else $error("open-load flag not set");

  oc_high_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in |=> ((hs_flags[3:2] & $past(hs_ev_in.oc[3:2])) == $past(hs_ev_in.oc[3:2])))
    else $error("overcurrent flag of switch three or four not set");

  oc_low_set_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in |=> ((hs_flags[1:0] & $past(hs_ev_in.oc[1:0])) == $past(hs_ev_in.oc[1:0])))
    else $error("overcurrent flag of switch one or two not set");

  // Clears, holds and freezes
  pin_read_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && rd_src && wake_ev_in.pin == 4'h0) |=> (ws_flags[3:0] == 4'h0))
    else $error("pin wake flags not cleared on read");

  failsafe_set_wins_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && fs_entry && wake_ev_in.lin) |=> ws_flags[7])
    else $error("wake event lost at fail-safe entry");

  level_freeze_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clk_en_in && !cyclic_sense_in && !lvl_live) |=> $stable(lvl_ff))
    else $error("level changed outside tracked modes");

  freeze_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !clk_en_in |=> ($stable(ws_flags) && $stable(hs_flags)))
    else $error("flags changed while frozen");

  wake_read_c: cover property (@(posedge clk_in) rd_src && ws_flags != 8'h00);
  hs_read_c: cover property (@(posedge clk_in) rd_hs && hs_flags != 12'h000);
  failsafe_c: cover property (@(posedge clk_in) fs_entry && ws_flags != 8'h00);
  sample_c: cover property (@(posedge clk_in) cyclic_sense_in && sample_strobe_in);
  freeze_c: cover property (@(posedge clk_in) !clk_en_in && rd_in.rd_req);

endmodule // wkhs_status_regs

// ---- bench/wkhs_host.sv ----
`timescale 1ns/1ns
// Host side reader of the status registers
module wkhs_host (
  // Clock
  input wire logic clk_in,
  // Read port
  output wkhs_pkg::wkhs_rd_t rd_out,
  input wire logic [15:0] rd_data_in,
  input wire logic rd_valid_in
);
  initial rd_out = '0;
  // One read; request moves only at falling edges
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    rd_out = '{rd_req: 1'b1, addr: a};
    @(negedge clk_in);
    rd_out = '{rd_req: 1'b0, addr: ~a}; // Stale address not left behind
    while (rd_valid_in !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    d = (rd_valid_in === 1'b1) ? rd_data_in : 16'hXXXX;
  endtask
endmodule // wkhs_host

// ---- bench/tb_wkhs_status_regs.sv ----
`timescale 1ns/1ns
module tb_wkhs_status_regs;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cyclic_sense_in = 1'b0;
  logic sample_strobe_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [3:0] wake_pin_in = 4'hA;
  wkhs_pkg::wkhs_mode_t mode_in = wkhs_pkg::WKHS_MODE_NORMAL;
  wkhs_pkg::wkhs_mode_t ms [3] = '{wkhs_pkg::WKHS_MODE_STOP, wkhs_pkg::WKHS_MODE_INIT,
    wkhs_pkg::WKHS_MODE_RESTART};
  wkhs_pkg::wkhs_wake_ev_t wake_ev_in = '0;
  wkhs_pkg::wkhs_hs_ev_t hs_ev_in = '0;
  wkhs_pkg::wkhs_rd_t rd_in;
  logic [15:0] rd_data_out;
  logic rd_valid_out;
  logic [15:0] d;
  int bad_count = 0;
  int comparisons = 0;
  // Clock, 8 ns period
  always #4 clk_in = ~clk_in;
  wkhs_status_regs #(.PINS(4)) i_wkhs_status_regs (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .mode_in(mode_in), .wake_pin_in(wake_pin_in),
    .cyclic_sense_in(cyclic_sense_in), .sample_strobe_in(sample_strobe_in),
    .wake_ev_in(wake_ev_in), .hs_ev_in(hs_ev_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out));
  wkhs_host i_wkhs_host (.clk_in(clk_in), .rd_out(rd_in), .rd_data_in(rd_data_out),
    .rd_valid_in(rd_valid_out));
  // Compare and count
  task automatic chk(input logic [6:0] a, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected reg %h expected %h seen %h", a, e, g);
    end
  endtask
  // Read one register and compare
  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    i_wkhs_host.rd(a, d);
    chk(a, e, d);
  endtask
  // One-cycle detector pulse, entered at a falling edge
  task automatic ev(input logic [7:0] w, input logic [11:0] h);
    wake_ev_in = w;
    hs_ev_in = h;
    @(negedge clk_in);
    wake_ev_in = '0;
    hs_ev_in = '0;
  endtask
  // Counts, verdict, end of run
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #40000;
    bad_count++;
    $display("unexpected timeout expected done seen hang");
    print_verdict();
  end
  // Test sequence
  initial begin
    repeat (20) @(negedge clk_in);
    sys_rst_in = 1'b0;
    rc(7'h44, 16'h0000);
    rc(7'h46, 16'h0000);
    rc(7'h47, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      ev(8'h01 << i, 12'h000);
      rc(7'h44, (i < 4) ? 16'h0001 << (10 - i) : 16'h0001 << (i - 4));
      rc(7'h44, 16'h0000);
    end
    for (int j = 0; j < 12; j++) begin
      ev(8'h00, 12'h001 << j);
      rc(7'h46, 16'h0001 << (j + j / 4));
      rc(7'h46, 16'h0000);
    end
    ev(8'hFF, 12'hFFF);
    rc(7'h44, 16'h078F);
    rc(7'h46, 16'h3DEF);
    $display("test flag map done");
    ev(8'h00, 12'h001);
    fork
      i_wkhs_host.rd(7'h46, d);
      begin
        @(negedge clk_in);
        ev(8'h10, 12'h001);
      end
    join
    chk(7'h46, 16'h0001, d);
    rc(7'h46, 16'h0001);
    rc(7'h44, 16'h0001);
    $display("test read collision done");
    ev(8'hFF, 12'hFFF);
    mode_in = wkhs_pkg::WKHS_MODE_FAILSAFE;
    repeat (2) @(negedge clk_in);
    rc(7'h44, 16'h0000);
    clk_en_in = 1'b0;
    i_wkhs_host.rd(7'h46, d);
    clk_en_in = 1'b1;
    rc(7'h46, 16'h3DEF);
    mode_in = wkhs_pkg::WKHS_MODE_NORMAL;
    $display("test fail-safe clear done");
    rc(7'h45, 16'h000A);
    for (int k = 0; k < 3; k++) begin
      mode_in = ms[k];
      wake_pin_in = 4'h5 + 4'(k);
      repeat (4) @(negedge clk_in);
      rc(7'h45, 16'h0005 + 16'(k));
    end
    mode_in = wkhs_pkg::WKHS_MODE_SLEEP;
    cyclic_sense_in = 1'b1;
    wake_pin_in = 4'hC;
    repeat (4) @(negedge clk_in);
    rc(7'h45, 16'h0007);
    sample_strobe_in = 1'b1;
    @(negedge clk_in);
    sample_strobe_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rc(7'h45, 16'h000C);
    cyclic_sense_in = 1'b0;
    wake_pin_in = 4'h3;
    repeat (4) @(negedge clk_in);
    rc(7'h45, 16'h000C);
    mode_in = wkhs_pkg::WKHS_MODE_NORMAL;
    repeat (4) @(negedge clk_in);
    rc(7'h45, 16'h0003);
    $display("test pin levels done");
    ev(8'hFF, 12'hFFF);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    rc(7'h44, 16'h0000);
    rc(7'h46, 16'h0000);
    rc(7'h45, 16'h0003);
    $display("test second reset done");
    print_verdict();
  end
endmodule // tb_wkhs_status_regs
